/* logic/dpm_dancer_position_monitor.sv */
// Dancer position monitor: source select, calibration, offset, filter,
// limit, deviation and web break supervision.
// Assumes motor_stopped, output_shutoff, run_command and fault_clear come
// from logic on core_clk; the offset capture strobe is an external pin.

`timescale 1ns/1ps

module dpm_dancer_position_monitor
  import dpm_pkg::*;
#(
  parameter int ADC_W     = 12,
  parameter int DIAM_W    = 16,
  parameter int TICK_CYC  = TICK_CYCLES
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [13:0]         feedback_source_select,
  input  wire logic [ADC_W-1:0]    analog_in_one,
  input  wire logic [ADC_W-1:0]    analog_in_two,
  input  wire logic [ADC_W-1:0]    analog_in_four,
  input  wire logic [ADC_W-1:0]    analog_in_six,
  input  wire logic [ADC_W-1:0]    input_one_bias_cal,
  input  wire logic [ADC_W-1:0]    input_one_gain_cal,
  input  wire logic [ADC_W-1:0]    input_two_bias_cal,
  input  wire logic [ADC_W-1:0]    input_two_gain_cal,
  input  wire logic [ADC_W-1:0]    input_four_bias_cal,
  input  wire logic [ADC_W-1:0]    input_four_gain_cal,
  input  wire logic [ADC_W-1:0]    input_six_bias_cal,
  input  wire logic [ADC_W-1:0]    input_six_gain_cal,
  input  wire logic signed [15:0]  fieldbus_feedback,
  input  wire logic [9:0]          feedback_filter_time_constant,
  input  wire logic signed [15:0]  target_position,
  input  wire logic [15:0]         in_range_detect_level,
  input  wire logic [15:0]         position_upper_limit,
  input  wire logic [15:0]         position_lower_limit,
  input  wire logic [15:0]         limit_hysteresis_width,
  input  wire logic [15:0]         break_wait_time,
  input  wire logic [15:0]         deviation_limit,
  input  wire logic [1:0]          limit_action_select,
  input  wire logic                offset_capture_strobe,
  input  wire logic                motor_stopped,
  input  wire logic                output_shutoff,
  input  wire logic                run_command,
  input  wire logic                fault_clear,
  input  wire logic [DIAM_W-1:0]   winding_diameter_in,
  output logic signed [15:0]       dancer_position,
  output logic [15:0]              feedback_offset_value,
  output logic                     position_in_range_flag,
  output logic                     upper_limit_flag,
  output logic                     lower_limit_flag,
  output logic                     deviation_limit_flag,
  output logic                     break_detected_flag,
  output logic                     pid_correction_enable,
  output logic                     limit_trip_fault,
  output logic [DIAM_W-1:0]        winding_diameter_hold
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]          sync;
    logic                strobe_level;
    logic signed [15:0]  meas;
    logic signed [15:0]  corr;
    logic [15:0]         offset;
    logic [15:0]         tick_cnt;
    logic [19:0]         brk_cnt;
    logic                brk;
    logic                in_range;
    logic                up_flag;
    logic                lo_flag;
    logic                dev_flag;
    logic                trip;
    logic [DIAM_W-1:0]   diam;
  } dpm_state_t;

  dpm_state_t          st;
  dpm_state_t          next_st;
  logic signed [15:0]  filt_out;
  logic                tick, cap_evt;
  logic                up_en, lo_en;
  logic                raw_beyond;
  logic                resume_ok;
  int                  src_pct;
  int                  fpos;
  int                  adev;
  int                  up_lim, lo_lim;
  int                  hyst;
  int                  wait_ms;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic int dpm_clamp(input int v);
    return (v > POS_FULL) ? POS_FULL : (v < -POS_FULL) ? -POS_FULL : v;
  endfunction

  // Divider is combinational; its result is registered into meas every core_clk cycle, not once per tick
  function automatic int dpm_scale(input logic [ADC_W-1:0] raw,
                                   input logic [ADC_W-1:0] bias,
                                   input logic [ADC_W-1:0] gain);
    int den;
    den = int'(gain) - int'(bias);
    return (den == 0) ? 0 :
           dpm_clamp((int'(raw) - int'(bias)) * POS_FULL / den);
  endfunction

  always_comb begin
    case (feedback_source_select)
      SRC_IN_TWO:   src_pct = dpm_scale(analog_in_two, input_two_bias_cal,
                                        input_two_gain_cal);
      SRC_IN_FOUR:  src_pct = dpm_scale(analog_in_four, input_four_bias_cal,
                                        input_four_gain_cal);
      SRC_IN_ONE:   src_pct = dpm_scale(analog_in_one, input_one_bias_cal,
                                        input_one_gain_cal);
      SRC_IN_SIX:   src_pct = dpm_scale(analog_in_six, input_six_bias_cal,
                                        input_six_gain_cal);
      SRC_FIELDBUS: src_pct = dpm_clamp(int'(fieldbus_feedback));
      default:      src_pct = 0;
    endcase
  end

  assign tick    = (st.tick_cnt == 16'(TICK_CYC - 1));
  // Only the second and third stages are looked at
  assign cap_evt = st.sync[1] && st.sync[2] && !st.strobe_level;
  assign fpos    = int'(filt_out);
  assign adev    = (fpos >= int'(target_position)) ?
                   fpos - int'(target_position) :
                   int'(target_position) - fpos;
  assign up_en   = (position_upper_limit != SETTING_OFF);
  assign lo_en   = (position_lower_limit != SETTING_OFF);
  assign up_lim  = (int'(position_upper_limit) - LIMIT_CENTER) * SETTING_SCALE;
  assign lo_lim  = (int'(position_lower_limit) - LIMIT_CENTER) * SETTING_SCALE;
  assign hyst    = (limit_hysteresis_width == SETTING_OFF) ? 0 :
                   int'(limit_hysteresis_width) * SETTING_SCALE;
  assign raw_beyond = (up_en && fpos > up_lim) ||
                      (lo_en && fpos < lo_lim);
  assign wait_ms = int'(break_wait_time) * MS_PER_WAIT_UNIT;
  assign resume_ok = (motor_stopped || output_shutoff) && !run_command;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.sync     = {st.sync[1:0], offset_capture_strobe};
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    if (st.sync[1] == st.sync[2]) begin
      next_st.strobe_level = st.sync[2];
    end
    next_st.meas = 16'(src_pct);
    if (cap_evt) begin
      next_st.offset = 16'(int'(st.meas) + OFFSET_BIAS_I);
    end
    next_st.corr = 16'(dpm_clamp(int'(st.meas) - int'(st.offset)
                                 + OFFSET_BIAS_I));
    next_st.in_range = (in_range_detect_level != SETTING_OFF) &&
      (adev <= int'(in_range_detect_level) * SETTING_SCALE);
    // Set past the limit by more than the width, clear once back at the limit
    if (!up_en) begin
      next_st.up_flag = 1'b0;
    end else if (fpos > up_lim + hyst) begin
      next_st.up_flag = 1'b1;
    end else if (fpos <= up_lim) begin
      next_st.up_flag = 1'b0;
    end
    if (!lo_en) begin
      next_st.lo_flag = 1'b0;
    end else if (fpos < lo_lim - hyst) begin
      next_st.lo_flag = 1'b1;
    end else if (fpos >= lo_lim) begin
      next_st.lo_flag = 1'b0;
    end
    next_st.dev_flag = (deviation_limit != SETTING_OFF) &&
      (adev > int'(deviation_limit) * SETTING_SCALE);
    if (!raw_beyond) begin
      next_st.brk_cnt = '0;
    end else if (tick && int'(st.brk_cnt) < wait_ms) begin
      next_st.brk_cnt = st.brk_cnt + 20'h00001;
    end
    // Set wins over resume, so a still-broken web stays latched
    if (break_wait_time != SETTING_OFF && raw_beyond &&
        int'(st.brk_cnt) >= wait_ms) begin
      next_st.brk = 1'b1;
    end else if (st.brk && resume_ok) begin
      next_st.brk = 1'b0;
    end
    if (!st.brk) begin
      next_st.diam = winding_diameter_in;
    end
    if (((limit_action_select == ACT_LIMITS ||
          limit_action_select == ACT_ALL) && (st.up_flag || st.lo_flag)) ||
        ((limit_action_select == ACT_DEVIATION ||
          limit_action_select == ACT_ALL) && st.dev_flag)) begin
      next_st.trip = 1'b1;
    end else if (fault_clear) begin
      next_st.trip = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st        <= '0;
      st.offset <= OFFSET_BIAS;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Filter and outputs
  // ----------------------------------------------------------------------
  dpm_lag_filter #(.W(16), .TCW(10)) u_filter (
    .core_clk      (core_clk),
    .rst           (rst),
    .sample_tick   (tick),
    .time_constant (feedback_filter_time_constant),
    .din           (st.corr),
    .dout          (filt_out)
  );

  assign dancer_position        = filt_out;
  assign feedback_offset_value  = st.offset;
  assign position_in_range_flag = st.in_range;
  assign upper_limit_flag       = st.up_flag;
  assign lower_limit_flag       = st.lo_flag;
  assign deviation_limit_flag   = st.dev_flag;
  assign break_detected_flag    = st.brk;
  assign pid_correction_enable  = !st.brk;
  assign limit_trip_fault       = st.trip;
  assign winding_diameter_hold  = st.diam;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking dpm_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_fieldbus_high;
    feedback_source_select == SRC_FIELDBUS && fieldbus_feedback > 16'sh2710;
  endsequence
  sequence s_capture;
    cap_evt ##1 1'b1;
  endsequence
  property p_fieldbus_sat;
    s_fieldbus_high |=> st.meas == 16'sh2710;
  endproperty
  a_fieldbus_sat: assert property (p_fieldbus_sat)
    else $error("fieldbus word not saturated");
  property p_meas_clamp;
    st.meas <= 16'sh2710 && st.meas >= -16'sh2710;
  endproperty
  a_meas_clamp: assert property (p_meas_clamp)
    else $error("measurement outside full scale");
  // Offset is stored from the measurement seen in the capture cycle
  property p_capture;
    s_capture |-> feedback_offset_value ==
      16'(int'($past(st.meas)) + OFFSET_BIAS_I);
  endproperty
  a_capture: assert property (p_capture)
    else $error("offset not captured from measurement");
  property p_bypass;
    feedback_filter_time_constant == 10'h000 |=>
      dancer_position == $past(st.corr);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero time constant did not bypass filter");
  property p_upper_set;
    up_en && fpos > up_lim + hyst |=> upper_limit_flag;
  endproperty
  a_upper_set: assert property (p_upper_set)
    else $error("upper limit flag missing");
  property p_lower_off;
    position_lower_limit == SETTING_OFF |=> !lower_limit_flag;
  endproperty
  a_lower_off: assert property (p_lower_off)
    else $error("disabled lower limit flagged");
  property p_break_now;
    break_wait_time == 16'h0000 && raw_beyond |=>
      break_detected_flag && !pid_correction_enable;
  endproperty
  a_break_now: assert property (p_break_now)
    else $error("zero wait break not declared");
  property p_restart;
    !raw_beyond |=> st.brk_cnt == 20'h00000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("break timer not restarted");
  property p_resume;
    st.brk && resume_ok && !raw_beyond |=> !break_detected_flag;
  endproperty
  a_resume: assert property (p_resume)
    else $error("break not released");
  property p_freeze;
    break_detected_flag && $past(break_detected_flag) |->
      $stable(winding_diameter_hold);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("diameter moved during break");
  property p_trip_all;
    limit_action_select == ACT_ALL && deviation_limit_flag |=>
      limit_trip_fault;
  endproperty
  a_trip_all: assert property (p_trip_all)
    else $error("deviation did not trip");
  property p_dev_off;
    deviation_limit == SETTING_OFF |=> !deviation_limit_flag;
  endproperty
  a_dev_off: assert property (p_dev_off)
    else $error("disabled deviation flagged");

endmodule

/* shared/dpm_pkg.sv */
// Constants shared by the dancer position monitor and its lag filter.
// Assumes one 20 MHz core clock; positions are signed, in 0.01 % units.

package dpm_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS  = 1_000_000;
  localparam int TICK_CYCLES   =
    (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Break wait setting is in 0.1 s, the tick is 1 ms
  localparam int MS_PER_WAIT_UNIT = 100;
  // Filter setting is in 0.01 s, the tick is 1 ms
  localparam int TC_SCALE         = 10;
  localparam int FILT_FRAC        = 12;

  // ----------------------------------------------------------------------
  // Source codes
  // ----------------------------------------------------------------------
  localparam logic [13:0] SRC_IN_TWO   = 14'h0003;
  localparam logic [13:0] SRC_IN_FOUR  = 14'h0004;
  localparam logic [13:0] SRC_IN_ONE   = 14'h0005;
  localparam logic [13:0] SRC_IN_SIX   = 14'h0006;
  localparam logic [13:0] SRC_FIELDBUS = 14'h0009;

  // ----------------------------------------------------------------------
  // Scaling and reset values
  // ----------------------------------------------------------------------
  localparam int          POS_FULL      = 10000;
  localparam logic [15:0] SETTING_OFF   = 16'h270F;
  localparam logic [15:0] OFFSET_BIAS   = 16'hC350;
  localparam int          OFFSET_BIAS_I = 50000;
  localparam int          LIMIT_CENTER  = 5000;
  localparam int          SETTING_SCALE = 10;

  // ----------------------------------------------------------------------
  // Limit action codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] ACT_FLAGS_ONLY = 2'h0;
  localparam logic [1:0] ACT_LIMITS     = 2'h1;
  localparam logic [1:0] ACT_DEVIATION  = 2'h2;
  localparam logic [1:0] ACT_ALL        = 2'h3;

endpackage

/* logic/dpm_lag_filter.sv */
// First-order lag filter stepped by a 1 ms sample tick.
// Assumes din is steady between ticks; a zero time constant bypasses it.

`timescale 1ns/1ps

module dpm_lag_filter
  import dpm_pkg::*;
#(
  parameter int W   = 16,
  parameter int TCW = 10
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 sample_tick,
  input  wire logic [TCW-1:0]       time_constant,
  input  wire logic signed [W-1:0]  din,
  output logic signed [W-1:0]       dout
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic signed [W+FILT_FRAC-1:0] acc;
  } dpm_filt_state_t;

  dpm_filt_state_t                st;
  dpm_filt_state_t                next_st;
  logic signed [W+FILT_FRAC-1:0]  target;
  logic signed [W+FILT_FRAC+1:0]  diff;
  int                             divisor;

  // Fraction bits keep small errors from stalling the settle
  assign target = (W + FILT_FRAC)'(din) <<< FILT_FRAC;

  // ----------------------------------------------------------------------
  // Update
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    diff    = '0;
    divisor = 1;
    if (time_constant == '0) begin
      next_st.acc = target;
    end else if (sample_tick) begin
      diff    = (W + FILT_FRAC + 2)'(target) - (W + FILT_FRAC + 2)'(st.acc);
      divisor = int'(time_constant) * TC_SCALE;
      next_st.acc = st.acc + (W + FILT_FRAC)'(diff / divisor);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st.acc <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = W'(st.acc >>> FILT_FRAC);

endmodule

/* sim/dpm_sensor_model.sv */
// Fieldbus master model feeding the dancer position feedback word.
// Assumes the word is sent LAG cycles after the bench asks for it.

`timescale 1ns/1ps

module dpm_sensor_model
#(
  parameter int LAG = 1
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic signed [15:0] word_cmd,
  output logic signed [15:0]      fieldbus_feedback
);
  // ----------------------------------------------------------------------
  // Delay line
  // ----------------------------------------------------------------------
  // Larger LAG models a slow master
  logic signed [15:0] pipe [LAG];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < LAG; i++) pipe[i] <= 16'h0000;
    end else begin
      pipe[0] <= word_cmd;
      for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i-1];
    end
  end

  assign fieldbus_feedback = pipe[LAG-1];
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the dancer position monitor.
// Assumes a 20 MHz core clock and a shortened 10 cycle sample tick.

`timescale 1ns/1ps

module tb_top;
  import dpm_pkg::*;
  logic               core_clk = 0, rst = 1, strobe = 0;
  logic [13:0]        src = SRC_FIELDBUS;
  logic [11:0]        an1 = 0, an2 = 0, an4 = 0, an6 = 0;
  logic [11:0]        bias = 12'h100, gain = 12'h900;
  logic signed [15:0] fb_cmd = 0, fb, target = 0, pos;
  logic [9:0]         tc = 0;
  logic [15:0]        lvl = 16'h0064, up = SETTING_OFF, lo = SETTING_OFF;
  logic [15:0]        hyst = SETTING_OFF, wt = SETTING_OFF, dlim = SETTING_OFF;
  logic [1:0]         act = 0;
  logic               mstop = 0, shut = 0, run = 1, fclr = 0;
  logic [15:0]        diam = 16'h1234, hold, offs;
  logic               inr, upf, lof, devf, brk, pid, trip;
  int                 error_cnt = 0, num_checks = 0, cyc = 0;

  dpm_sensor_model #(.LAG(2)) u_dpm_sensor_model (
    .core_clk(core_clk), .rst(rst), .word_cmd(fb_cmd),
    .fieldbus_feedback(fb));

  dpm_dancer_position_monitor #(.TICK_CYC(10)) u_dpm_dancer_position_monitor (
    .core_clk(core_clk), .rst(rst), .feedback_source_select(src),
    .analog_in_one(an1), .analog_in_two(an2), .analog_in_four(an4),
    .analog_in_six(an6), .input_one_bias_cal(bias),
    .input_one_gain_cal(gain), .input_two_bias_cal(bias),
    .input_two_gain_cal(gain), .input_four_bias_cal(bias),
    .input_four_gain_cal(gain), .input_six_bias_cal(bias),
    .input_six_gain_cal(gain), .fieldbus_feedback(fb),
    .feedback_filter_time_constant(tc), .target_position(target),
    .in_range_detect_level(lvl), .position_upper_limit(up),
    .position_lower_limit(lo), .limit_hysteresis_width(hyst),
    .break_wait_time(wt), .deviation_limit(dlim),
    .limit_action_select(act), .offset_capture_strobe(strobe),
    .motor_stopped(mstop), .output_shutoff(shut), .run_command(run),
    .fault_clear(fclr), .winding_diameter_in(diam),
    .dancer_position(pos), .feedback_offset_value(offs),
    .position_in_range_flag(inr), .upper_limit_flag(upf),
    .lower_limit_flag(lof), .deviation_limit_flag(devf),
    .break_detected_flag(brk), .pid_correction_enable(pid),
    .limit_trip_fault(trip), .winding_diameter_hold(hold));

  // ----------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------------
  initial forever #25 core_clk = ~core_clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Whole run is about 2300 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: cycles %h limit %h", $time, cyc, 20000);
      final_report();
    end
  end

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Output terminal as the configurator codes it; +100 gives low-true
  function automatic logic [15:0] term_out(int code);
    case (code)
      14:      return {15'h0000, lof};
      114:     return {15'h0000, !lof};
      15:      return {15'h0000, upf};
      115:     return {15'h0000, !upf};
      231:     return {15'h0000, brk};
      331:     return {15'h0000, !brk};
      235:     return {15'h0000, inr};
      335:     return {15'h0000, !inr};
      default: return 16'hFFFF;
    endcase
  endfunction

  // Pipeline plus model lag is at most 7 cycles (trip), just under the 8 waited
  task automatic setp(logic [15:0] v);
    fb_cmd = v;
    step(8);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_fieldbus();
    setp(16'h2EE0); chk(pos, 16'h2710);
    setp(16'h8000); chk(pos, 16'hD8F0);
    setp(16'h04D2); chk(pos, 16'h04D2);
    $display("fieldbus done");
  endtask

  task automatic t_analog();
    logic [13:0] codes [4] = '{SRC_IN_TWO, SRC_IN_FOUR, SRC_IN_ONE,
                               SRC_IN_SIX};
    for (int k = 0; k < 4; k++) begin
      src = codes[k];
      {an2, an4, an1, an6} = {4{bias}};
      if (k == 0) an2 = 12'h500;
      if (k == 1) an4 = 12'h500;
      if (k == 2) an1 = 12'h500;
      if (k == 3) an6 = 12'h500;
      step(8);
      chk(pos, 16'h1388);
    end
    src = SRC_IN_ONE; an1 = 12'hD00; step(8);
    chk(pos, 16'h2710);
    src = 14'h0000; step(8);
    chk(pos, 16'h0000);
    src = SRC_FIELDBUS; step(8);
    $display("analog done");
  endtask

  task automatic t_limits();
    up = 16'h157C; lo = 16'h1194;
    setp(16'h1389); chk(upf, 1);
    chk(term_out(115), 0);
    setp(16'h1388); chk(upf, 0);
    setp(16'hEC77); chk(lof, 1);
    chk(term_out(14), 1);
    setp(16'hEC78); chk(lof, 0);
    hyst = 16'h0064;
    setp(16'h157C); chk(upf, 0);
    setp(16'h1771); chk(upf, 1);
    setp(16'h157C); chk(upf, 1);
    setp(16'h1388); chk(upf, 0);
    up = SETTING_OFF; lo = SETTING_OFF;
    setp(16'h2710); chk(upf, 0);
    setp(16'hD8F0); chk(lof, 0);
    hyst = SETTING_OFF;
    $display("limits done");
  endtask

  task automatic t_deviation();
    target = 16'h01F4; dlim = 16'h0064;
    setp(16'h05DD); chk(devf, 1); chk(inr, 0);
    setp(16'h05DB); chk(devf, 0); chk(inr, 1);
    chk(term_out(235), 1); chk(term_out(335), 0);
    dlim = SETTING_OFF;
    setp(16'h2710); chk(devf, 0);
    target = 0;
    $display("deviation done");
  endtask

  // Codes 1 and 3 trip on limits, 2 and 3 on deviation
  task automatic t_trip();
    for (int a = 0; a < 4; a++) begin
      for (int k = 0; k < 2; k++) begin
        act = 2'(a);
        up = k ? SETTING_OFF : 16'h157C;
        dlim = k ? 16'h0064 : SETTING_OFF;
        fb_cmd = 0; fclr = 1; step(8); fclr = 0;
        setp(k ? 16'h07D0 : 16'h1770);
        chk(trip, k ? a[1] : a[0]);
      end
    end
    act = 0; up = SETTING_OFF; dlim = SETTING_OFF;
    fb_cmd = 0; fclr = 1; step(8); fclr = 0;
    $display("trip done");
  endtask

  task automatic t_break();
    int n;
    up = 16'h157C; hyst = 16'h0064; wt = 16'h0001;
    setp(16'h1770); chk(upf, 0);
    step(890); chk(brk, 0);
    setp(16'h0000);
    setp(16'h1770); step(890); chk(brk, 0);
    n = 0;
    while (brk !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    chk(brk, 1); chk(pid, 0);
    chk(term_out(231), 1); chk(term_out(331), 0);
    diam = 16'h5678; step(5);
    chk(hold, 16'h1234);
    mstop = 1; setp(16'h0000);
    chk(brk, 1);
    run = 0; step(8);
    chk(brk, 0); chk(pid, 1);
    // Zero wait breaks at once; beyond a limit, set beats resume
    wt = 16'h0000;
    setp(16'h1770); chk(brk, 1);
    setp(16'h0000); chk(brk, 0);
    up = SETTING_OFF; hyst = SETTING_OFF; wt = SETTING_OFF;
    mstop = 0; run = 1;
    $display("break done");
  endtask

  task automatic t_filter();
    tc = 10'h001;
    setp(16'h2710); step(7);
    num_checks++;
    if ((pos > 0 && pos < 16'sh2710) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, pos, 16'h2710);
    end
    tc = 0; step(8);
    chk(pos, 16'h2710);
    $display("filter done");
  endtask

  task automatic t_offset();
    setp(16'h0BB8);
    strobe = 1; step(3); strobe = 0; step(8);
    chk(offs, 16'hCF08);
    chk(pos, 16'h0000);
    setp(16'hE0C0); chk(pos, 16'hD8F0);
    $display("offset done");
  endtask

  // Mid-run reset must drop the captured offset back to the bias
  task automatic t_reset();
    rst = 1; step(2); rst = 0; step(1);
    chk(offs, OFFSET_BIAS); chk(pos, 16'h0000);
    step(8); chk(pos, 16'hE0C0);
    $display("reset done");
  endtask

  initial begin
    step(5);
    rst = 0;
    step(1);
    chk(pos, 16'h0000); chk(offs, OFFSET_BIAS); chk(pid, 1);
    chk({upf, lof, devf, brk, trip}, 16'h0000);
    t_fieldbus();
    t_analog();
    t_limits();
    t_deviation();
    t_trip();
    t_break();
    t_filter();
    t_offset();
    t_reset();
    final_report();
  end
endmodule
